// file: design/cfmt_pkg.sv
// Shared constants, register map and carrier types of the CAN filter, mailbox and timer slice
package cfmt_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int OBJ_COUNT = 15;
  localparam int OBJ_W = 4;
  localparam int BYTES_PER_OBJ = 8;
  localparam int IDX_W = 3;
  localparam int MBOX_DEPTH = OBJ_COUNT * BYTES_PER_OBJ;
  localparam int MBOX_AW = 7;
  localparam int ID_W = 29;
  localparam int TIMER_W = 16;

  // ****************************************************************
  // Special function register byte addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_TIMER_PRESCALE = 8'hA1;
  localparam logic [7:0] ADDR_MAILBOX_DATA_PORT = 8'hA3;
  localparam logic [7:0] ADDR_TTC_TIMER_LOW = 8'hA4;
  localparam logic [7:0] ADDR_TTC_TIMER_HIGH = 8'hA5;
  localparam logic [7:0] ADDR_MESSAGE_TIMER_LOW = 8'hAC;
  localparam logic [7:0] ADDR_MESSAGE_TIMER_HIGH = 8'hAD;
  localparam logic [7:0] ADDR_STAMP_LOW = 8'hAE;
  localparam logic [7:0] ADDR_STAMP_HIGH = 8'hAF;
  localparam logic [7:0] ADDR_EXT_ID_MASK_1 = 8'hC4;
  localparam logic [7:0] ADDR_EXT_ID_MASK_2 = 8'hC5;
  localparam logic [7:0] ADDR_EXT_ID_MASK_3 = 8'hC6;
  localparam logic [7:0] ADDR_EXT_ID_MASK_4 = 8'hC7;

  // ****************************************************************
  // Field layout of the fourth mask register
  // ****************************************************************
  localparam int MASK4_IDE_BIT = 0;
  localparam int MASK4_RSVD_BIT = 1;
  localparam int MASK4_RTR_BIT = 2;
  localparam int MASK4_ID_LSB = 3;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] TIMER_PRESCALE_RST = 8'h00;
  localparam logic [TIMER_W-1:0] TIMER_RST = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [IDX_W-1:0] IDX_ZERO = 3'h0;
  localparam logic [IDX_W-1:0] IDX_STEP = 3'h1;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [ID_W-1:0] id;
    logic rtr;
    logic ide;
  } cfmt_frame_s;

  typedef struct packed {
    logic [IDX_W-1:0] byte_idx;
    logic [7:0] rdata;
    logic [TIMER_W-1:0] stamp;
    logic [TIMER_W-1:0] ttc;
    logic acc_valid;
    logic accept;
  } cfmt_ctl_s;

  typedef struct packed {
    logic [OBJ_COUNT-1:0][ID_W-1:0] id_mask;
    logic [OBJ_COUNT-1:0] rtr_mask;
    logic [OBJ_COUNT-1:0] ide_mask;
  } cfmt_mask_s;

  typedef struct packed {
    cfmt_ctl_s ctl;
    cfmt_mask_s msk;
  } cfmt_state_s;

endpackage

// file: design/cfmt_mbox_mem.sv
// Mailbox byte memory with one write port and one registered read port
`timescale 1ns/1ns
module cfmt_mbox_mem #(
  parameter int DEPTH = cfmt_pkg::MBOX_DEPTH,
  parameter int AW = cfmt_pkg::MBOX_AW
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [7:0] rdata_o
);
  import cfmt_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [7:0] q;
  } cfmt_mem_s;

  cfmt_mem_s st;
  cfmt_mem_s next_st;

  // Contents carry no reset: mailbox bytes are undefined until written
  always_comb begin
    next_st = st;
    if (we_i && (int'(waddr_i) < DEPTH)) begin
      next_st.mem[waddr_i] = wdata_i;
    end
    next_st.q = (int'(raddr_i) < DEPTH) ? st.mem[raddr_i] : BYTE_ZERO;
  end

  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  assign rdata_o = st.q;
endmodule

// file: design/cfmt_timer.sv
// CAN timer prescaler and 16-bit message timer with byte-wise software load
`timescale 1ns/1ns
module cfmt_timer #(
  parameter int W = cfmt_pkg::TIMER_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic [7:0] divider_i,
  input wire logic wr_low_i,
  input wire logic wr_high_i,
  input wire logic [7:0] wdata_i,
  output logic [W-1:0] count_o
);
  import cfmt_pkg::*;

  typedef struct packed {
    logic [7:0] presc_cnt;
    logic [W-1:0] count;
  } cfmt_tmr_s;

  cfmt_tmr_s st;
  cfmt_tmr_s next_st;

  // Divides the base tick by divider plus one, so 0 passes every tick
  always_comb begin
    next_st = st;
    if (tick_i) begin
      if (st.presc_cnt >= divider_i) begin
        next_st.presc_cnt = BYTE_ZERO;
        next_st.count = st.count + W'(1);
      end else begin
        next_st.presc_cnt = st.presc_cnt + 8'h01;
      end
    end
    // A software write to a byte wins over the count step of that cycle
    if (wr_low_i) begin
      next_st.count[7:0] = wdata_i;
    end
    if (wr_high_i) begin
      next_st.count[W-1:8] = (W-8)'(wdata_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st.presc_cnt <= BYTE_ZERO;
      st.count <= W'(TIMER_RST);
    end else begin
      st <= next_st;
    end
  end

  assign count_o = st.count;
endmodule

// file: design/cfmt_regs.sv
// Acceptance mask registers, mailbox data port and CAN timer registers
`timescale 1ns/1ns
// Summary of operation
// - Each identifier mask bit at 0 forces its comparison true and at 1 compares it with the tag.
// - Bit 2 of the fourth mask register masks or enables the remote-request comparison.
// - Bit 0 of the fourth mask register masks or enables the extension-format comparison.
// - Masks apply only when filtering received frames and are ignored for transmit objects.
// - Bit 1 of the fourth mask register is reserved, reads undefined and must not be set; this slice stores nothing there and reads it as 0.
// - Mask registers leave reset undefined and software programs them before reception.
// - The data port reaches the byte of the selected object at object pointer plus index.
// - With auto-increment each data port access steps the index by one, wrapping 7 to 0.
// - An 8-bit prescaler, 0 to 255 and reset to zero, divides the main CAN timer clock.
// - The 16-bit message timer is seen as high and low bytes, the high byte resetting to zero.
// - A read-only 16-bit time stamp is read at high byte AFh and low byte AEh.
// - A read-only 16-bit time-triggered timer is read at high byte A5h and low byte A4h.
module cfmt_regs (
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  input wire logic [7:0] SFR_WDATA_I,
  output logic [7:0] SFR_RDATA_O,
  input wire logic [cfmt_pkg::OBJ_W-1:0] PAGE_OBJ_I,
  input wire logic [cfmt_pkg::IDX_W-1:0] PAGE_IDX_I,
  input wire logic PAGE_LOAD_I,
  input wire logic PAGE_AUTOINC_I,
  output logic [cfmt_pkg::IDX_W-1:0] PAGE_IDX_O,
  input wire logic ACC_REQ_I,
  input wire logic [cfmt_pkg::OBJ_W-1:0] ACC_OBJ_I,
  input wire logic ACC_OBJ_TX_I,
  input wire cfmt_pkg::cfmt_frame_s ACC_FRAME_I,
  input wire cfmt_pkg::cfmt_frame_s ACC_TAG_I,
  output logic ACC_VALID_O,
  output logic ACC_MATCH_O,
  input wire logic TIMER_TICK_I,
  input wire logic STAMP_CAPTURE_I,
  input wire logic TTC_CAPTURE_I,
  output logic [cfmt_pkg::TIMER_W-1:0] MESSAGE_TIMER_O
);
  import cfmt_pkg::*;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic logic [MBOX_AW-1:0] mbox_addr(input logic [OBJ_W-1:0] obj,
                                                   input logic [IDX_W-1:0] idx);
    logic [MBOX_AW-1:0] base;
    base = MBOX_AW'(obj) << IDX_W;
    mbox_addr = base | MBOX_AW'(idx);
  endfunction

  // Masked compare: a differing bit only counts where the mask enables it
  function automatic logic masked_equal(input cfmt_frame_s frm, input cfmt_frame_s tag,
                                        input cfmt_frame_s msk);
    cfmt_frame_s diff;
    diff = frm ^ tag;
    masked_equal = ((diff & msk) == '0);
  endfunction

  function automatic logic obj_ok(input logic [OBJ_W-1:0] obj);
    obj_ok = (int'(obj) < OBJ_COUNT);
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  cfmt_state_s st;
  cfmt_state_s next_st;
  logic [TIMER_W-1:0] timer_count;
  logic [7:0] mbox_q;
  logic [7:0] prescale;
  logic [7:0] next_prescale;
  logic mbox_hit;
  logic mbox_we;
  logic mask_we;
  logic wr_tim_low;
  logic wr_tim_high;
  logic [MBOX_AW-1:0] cur_addr;
  cfmt_frame_s sel_mask;
  cfmt_frame_s acc_mask;
  cfmt_frame_s full_mask;

  assign mbox_hit = (SFR_ADDR_I == ADDR_MAILBOX_DATA_PORT) && (SFR_WR_I || SFR_RD_I);
  assign mbox_we = SFR_WR_I && (SFR_ADDR_I == ADDR_MAILBOX_DATA_PORT) && obj_ok(PAGE_OBJ_I);
  assign mask_we = SFR_WR_I && obj_ok(PAGE_OBJ_I);
  assign wr_tim_low = SFR_WR_I && (SFR_ADDR_I == ADDR_MESSAGE_TIMER_LOW);
  assign wr_tim_high = SFR_WR_I && (SFR_ADDR_I == ADDR_MESSAGE_TIMER_HIGH);
  assign cur_addr = mbox_addr(PAGE_OBJ_I, st.ctl.byte_idx);

  // ****************************************************************
  // Mailbox memory and message timer
  // ****************************************************************
  cfmt_mbox_mem #(
    .DEPTH(MBOX_DEPTH),
    .AW(MBOX_AW)
  ) u_mbox (
    .clk_i(CLK_SYS_I),
    .we_i(mbox_we),
    .waddr_i(cur_addr),
    .wdata_i(SFR_WDATA_I),
    .raddr_i(cur_addr),
    .rdata_o(mbox_q)
  );

  cfmt_timer #(
    .W(TIMER_W)
  ) u_timer (
    .clk_i(CLK_SYS_I),
    .rst_i(SYS_RST_I),
    .tick_i(TIMER_TICK_I),
    .divider_i(prescale),
    .wr_low_i(wr_tim_low),
    .wr_high_i(wr_tim_high),
    .wdata_i(SFR_WDATA_I),
    .count_o(timer_count)
  );

  // ****************************************************************
  // Prescaler register
  // ****************************************************************
  always_comb begin
    next_prescale = prescale;
    if (SFR_WR_I && (SFR_ADDR_I == ADDR_TIMER_PRESCALE)) begin
      next_prescale = SFR_WDATA_I;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      prescale <= TIMER_PRESCALE_RST;
    end else begin
      prescale <= next_prescale;
    end
  end

  // ****************************************************************
  // Mask views of the selected and the queried object
  // ****************************************************************
  always_comb begin
    sel_mask = '0;
    acc_mask = '0;
    if (obj_ok(PAGE_OBJ_I)) begin
      sel_mask.id = st.msk.id_mask[PAGE_OBJ_I];
      sel_mask.rtr = st.msk.rtr_mask[PAGE_OBJ_I];
      sel_mask.ide = st.msk.ide_mask[PAGE_OBJ_I];
    end
    if (obj_ok(ACC_OBJ_I)) begin
      acc_mask.id = st.msk.id_mask[ACC_OBJ_I];
      acc_mask.rtr = st.msk.rtr_mask[ACC_OBJ_I];
      acc_mask.ide = st.msk.ide_mask[ACC_OBJ_I];
    end
    full_mask = '1;
  end

  // ****************************************************************
  // Register file, index pointer, captures and acceptance
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_st.ctl.acc_valid = 1'b0;

    // Mask writes go to the object selected by the page pointer
    if (mask_we) begin
      case (SFR_ADDR_I)
        ADDR_EXT_ID_MASK_1: begin
          next_st.msk.id_mask[PAGE_OBJ_I][28:21] = SFR_WDATA_I;
        end
        ADDR_EXT_ID_MASK_2: begin
          next_st.msk.id_mask[PAGE_OBJ_I][20:13] = SFR_WDATA_I;
        end
        ADDR_EXT_ID_MASK_3: begin
          next_st.msk.id_mask[PAGE_OBJ_I][12:5] = SFR_WDATA_I;
        end
        ADDR_EXT_ID_MASK_4: begin
          next_st.msk.id_mask[PAGE_OBJ_I][4:0] = SFR_WDATA_I[7:MASK4_ID_LSB];
          next_st.msk.rtr_mask[PAGE_OBJ_I] = SFR_WDATA_I[MASK4_RTR_BIT];
          // Reserved bit has no storage, so a stray one cannot steer anything
          next_st.msk.ide_mask[PAGE_OBJ_I] = SFR_WDATA_I[MASK4_IDE_BIT];
        end
        default: begin
        end
      endcase
    end

    // Page load wins over a data port step in the same cycle
    if (PAGE_LOAD_I) begin
      next_st.ctl.byte_idx = PAGE_IDX_I;
    end else if (mbox_hit && PAGE_AUTOINC_I) begin
      next_st.ctl.byte_idx = st.ctl.byte_idx + IDX_STEP;
    end

    if (STAMP_CAPTURE_I) begin
      next_st.ctl.stamp = timer_count;
    end
    if (TTC_CAPTURE_I) begin
      next_st.ctl.ttc = timer_count;
    end

    if (SFR_RD_I) begin
      case (SFR_ADDR_I)
        ADDR_TIMER_PRESCALE: next_st.ctl.rdata = prescale;
        ADDR_MAILBOX_DATA_PORT: next_st.ctl.rdata = mbox_q;
        ADDR_TTC_TIMER_LOW: next_st.ctl.rdata = st.ctl.ttc[7:0];
        ADDR_TTC_TIMER_HIGH: next_st.ctl.rdata = st.ctl.ttc[15:8];
        ADDR_MESSAGE_TIMER_LOW: next_st.ctl.rdata = timer_count[7:0];
        ADDR_MESSAGE_TIMER_HIGH: next_st.ctl.rdata = timer_count[15:8];
        ADDR_STAMP_LOW: next_st.ctl.rdata = st.ctl.stamp[7:0];
        ADDR_STAMP_HIGH: next_st.ctl.rdata = st.ctl.stamp[15:8];
        ADDR_EXT_ID_MASK_1: next_st.ctl.rdata = sel_mask.id[28:21];
        ADDR_EXT_ID_MASK_2: next_st.ctl.rdata = sel_mask.id[20:13];
        ADDR_EXT_ID_MASK_3: next_st.ctl.rdata = sel_mask.id[12:5];
        ADDR_EXT_ID_MASK_4: begin
          next_st.ctl.rdata = {sel_mask.id[4:0], sel_mask.rtr, 1'b0, sel_mask.ide};
        end
        default: next_st.ctl.rdata = BYTE_ZERO;
      endcase
    end

    // Transmit objects compare every bit, so their mask contents have no effect
    if (ACC_REQ_I) begin
      next_st.ctl.acc_valid = 1'b1;
      if (!obj_ok(ACC_OBJ_I)) begin
        next_st.ctl.accept = 1'b0;
      end else if (ACC_OBJ_TX_I) begin
        next_st.ctl.accept = masked_equal(ACC_FRAME_I, ACC_TAG_I, full_mask);
      end else begin
        next_st.ctl.accept = masked_equal(ACC_FRAME_I, ACC_TAG_I, acc_mask);
      end
    end
  end

  // Masks are deliberately left out of reset; software must program them first
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      st.ctl.byte_idx <= IDX_ZERO;
      st.ctl.rdata <= BYTE_ZERO;
      st.ctl.stamp <= TIMER_RST;
      st.ctl.ttc <= TIMER_RST;
      st.ctl.acc_valid <= 1'b0;
      st.ctl.accept <= 1'b0;
      st.msk <= next_st.msk;
    end else begin
      st <= next_st;
    end
  end

  assign SFR_RDATA_O = st.ctl.rdata;
  assign PAGE_IDX_O = st.ctl.byte_idx;
  assign ACC_VALID_O = st.ctl.acc_valid;
  assign ACC_MATCH_O = st.ctl.accept;
  assign MESSAGE_TIMER_O = timer_count;
endmodule

// file: verification/cfmt_regs_props.sv
// Port-level assertions for the CAN filter, mailbox and timer register slice
`timescale 1ns/1ns
module cfmt_regs_props (
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  input wire logic [7:0] SFR_WDATA_I,
  input wire logic [7:0] SFR_RDATA_O,
  input wire logic [cfmt_pkg::OBJ_W-1:0] PAGE_OBJ_I,
  input wire logic [cfmt_pkg::IDX_W-1:0] PAGE_IDX_I,
  input wire logic PAGE_LOAD_I,
  input wire logic PAGE_AUTOINC_I,
  input wire logic [cfmt_pkg::IDX_W-1:0] PAGE_IDX_O,
  input wire logic ACC_REQ_I,
  input wire logic [cfmt_pkg::OBJ_W-1:0] ACC_OBJ_I,
  input wire logic ACC_OBJ_TX_I,
  input wire cfmt_pkg::cfmt_frame_s ACC_FRAME_I,
  input wire cfmt_pkg::cfmt_frame_s ACC_TAG_I,
  input wire logic ACC_VALID_O,
  input wire logic ACC_MATCH_O,
  input wire logic [cfmt_pkg::TIMER_W-1:0] MESSAGE_TIMER_O
);
  import cfmt_pkg::*;
  // ****************************************************************
  // Checks
  // ****************************************************************
  logic port_acc;
  // Object 15 accesses are left out of the step check only: their effect on the index is unspecified
  assign port_acc = (SFR_WR_I || SFR_RD_I) && SFR_ADDR_I == ADDR_MAILBOX_DATA_PORT;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);
  sequence s_presc_wr_rd;
    SFR_WR_I && SFR_ADDR_I == ADDR_TIMER_PRESCALE
      ##2 SFR_RD_I && SFR_ADDR_I == ADDR_TIMER_PRESCALE;
  endsequence
  property p_valid; ACC_REQ_I |=> ACC_VALID_O; endproperty
  a_valid: assert property (p_valid) else $error("acceptance answer missing");
  property p_cause; ACC_VALID_O |-> $past(ACC_REQ_I); endproperty
  a_cause: assert property (p_cause) else $error("answer without query");
  property p_exact; ACC_REQ_I && ACC_OBJ_I != 4'hF && ACC_FRAME_I == ACC_TAG_I |=> ACC_MATCH_O;
  endproperty
  a_exact: assert property (p_exact) else $error("equal frame refused");
  property p_tx; ACC_REQ_I && ACC_OBJ_TX_I && ACC_FRAME_I != ACC_TAG_I |=> !ACC_MATCH_O;
  endproperty
  a_tx: assert property (p_tx) else $error("transmit object used mask");
  property p_load; PAGE_LOAD_I |=> PAGE_IDX_O == $past(PAGE_IDX_I); endproperty
  a_load: assert property (p_load) else $error("index load lost");
  property p_step;
    port_acc && PAGE_OBJ_I != 4'hF && PAGE_AUTOINC_I && !PAGE_LOAD_I
      |=> PAGE_IDX_O == $past(PAGE_IDX_O) + IDX_STEP;
  endproperty
  a_step: assert property (p_step) else $error("index step wrong");
  property p_hold; !PAGE_LOAD_I && !port_acc |=> $stable(PAGE_IDX_O); endproperty
  a_hold: assert property (p_hold) else $error("index moved unasked");
  property p_noinc; port_acc && !PAGE_AUTOINC_I && !PAGE_LOAD_I |=> $stable(PAGE_IDX_O);
  endproperty
  a_noinc: assert property (p_noinc) else $error("index stepped with increment off");
  property p_presc; s_presc_wr_rd |=> SFR_RDATA_O == $past(SFR_WDATA_I, 3); endproperty
  a_presc: assert property (p_presc) else $error("prescale read back wrong");
  property p_timhi;
    SFR_WR_I && SFR_ADDR_I == ADDR_MESSAGE_TIMER_HIGH
      |=> MESSAGE_TIMER_O[15:8] == $past(SFR_WDATA_I);
  endproperty
  a_timhi: assert property (p_timhi) else $error("timer high write lost");
  property p_rsvd;
    SFR_RD_I && SFR_ADDR_I == ADDR_EXT_ID_MASK_4 |=> !SFR_RDATA_O[MASK4_RSVD_BIT];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved mask bit set");
endmodule
bind cfmt_regs cfmt_regs_props u_props (.CLK_SYS_I, .SYS_RST_I, .SFR_ADDR_I, .SFR_WR_I,
  .SFR_RD_I, .SFR_WDATA_I, .SFR_RDATA_O, .PAGE_OBJ_I, .PAGE_IDX_I, .PAGE_LOAD_I,
  .PAGE_AUTOINC_I, .PAGE_IDX_O, .ACC_REQ_I, .ACC_OBJ_I, .ACC_OBJ_TX_I, .ACC_FRAME_I,
  .ACC_TAG_I, .ACC_VALID_O, .ACC_MATCH_O, .MESSAGE_TIMER_O);

// file: verification/cfmt_regs_bench.sv
// Self-checking bench for the CAN filter, mailbox and timer register slice
`timescale 1ns/1ns
module cfmt_regs_bench;
  import cfmt_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [OBJ_W-1:0] pobj = 4'h2;
  logic [IDX_W-1:0] pidx = 3'h0;
  logic pload = 1'b0;
  logic ainc = 1'b1;
  logic [IDX_W-1:0] idx;
  logic req = 1'b0;
  logic [OBJ_W-1:0] aobj = 4'h2;
  logic atx = 1'b0;
  cfmt_frame_s frm = '0;
  cfmt_frame_s tag = '0;
  logic avalid;
  logic amatch;
  logic tick = 1'b0;
  logic scap = 1'b0;
  logic tcap = 1'b0;
  logic [TIMER_W-1:0] tmr;
  int fails = 0;
  int checks_done = 0;
  always #2 clk = ~clk;
  // Tag starts at zero so most expectations read straight off the frame bits
  cfmt_regs DUT (.CLK_SYS_I(clk), .SYS_RST_I(rst), .SFR_ADDR_I(addr), .SFR_WR_I(wr),
    .SFR_RD_I(rd), .SFR_WDATA_I(wdata), .SFR_RDATA_O(rdata), .PAGE_OBJ_I(pobj),
    .PAGE_IDX_I(pidx), .PAGE_LOAD_I(pload), .PAGE_AUTOINC_I(ainc), .PAGE_IDX_O(idx),
    .ACC_REQ_I(req), .ACC_OBJ_I(aobj), .ACC_OBJ_TX_I(atx), .ACC_FRAME_I(frm),
    .ACC_TAG_I(tag), .ACC_VALID_O(avalid), .ACC_MATCH_O(amatch),
    .TIMER_TICK_I(tick), .STAMP_CAPTURE_I(scap), .TTC_CAPTURE_I(tcap), .MESSAGE_TIMER_O(tmr));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic final_report();
    if (fails == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Returns a cycle after the strobe, so port reads are always two cycles apart
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, {8'h00, rdata}, {8'h00, exp});
  endtask
  task automatic acc(input logic [3:0] o, input logic tx, input cfmt_frame_s f, input logic e);
    @(posedge clk);
    req <= 1'b1;
    aobj <= o;
    atx <= tx;
    frm <= f;
    @(posedge clk);
    req <= 1'b0;
    #1;
    chk("valid", {15'h0000, avalid}, 16'h0001);
    chk("match", {15'h0000, amatch}, {15'h0000, e});
  endtask
  task automatic load(input logic [3:0] o, input logic [2:0] i);
    @(posedge clk);
    pobj <= o;
    pidx <= i;
    pload <= 1'b1;
    @(posedge clk);
    pload <= 1'b0;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
    end
    repeat (2) @(posedge clk);
    #1;
  endtask
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("index", {13'h0000, idx}, 16'h0000);
    chk("timer", tmr, TIMER_RST);
    rd_chk(ADDR_TIMER_PRESCALE, TIMER_PRESCALE_RST, "prescale");
    rd_chk(ADDR_MESSAGE_TIMER_HIGH, BYTE_ZERO, "timer_high");
    rd_chk(8'h00, BYTE_ZERO, "unmapped");
    wr_reg(ADDR_EXT_ID_MASK_1, 8'hFF);
    wr_reg(ADDR_EXT_ID_MASK_2, 8'h00);
    wr_reg(ADDR_EXT_ID_MASK_3, 8'hF0);
    wr_reg(ADDR_EXT_ID_MASK_4, 8'hFD);
    rd_chk(ADDR_EXT_ID_MASK_1, 8'hFF, "mask1");
    rd_chk(ADDR_EXT_ID_MASK_3, 8'hF0, "mask3");
    rd_chk(ADDR_EXT_ID_MASK_4, 8'hFD, "mask4");
    acc(4'h2, 1'b0, {29'h0000_0000, 2'h0}, 1'b1);
    acc(4'h2, 1'b0, {29'h0000_2000, 2'h0}, 1'b1);
    acc(4'h2, 1'b0, {29'h0020_0000, 2'h0}, 1'b0);
    acc(4'h2, 1'b0, {29'h0000_0020, 2'h0}, 1'b1);
    acc(4'h2, 1'b0, {29'h0000_0200, 2'h0}, 1'b0);
    acc(4'h2, 1'b0, {29'h0000_0001, 2'h0}, 1'b0);
    acc(4'h2, 1'b0, {29'h0000_0000, 2'h2}, 1'b0);
    acc(4'h2, 1'b0, {29'h0000_0000, 2'h1}, 1'b0);
    acc(4'h2, 1'b1, {29'h0000_2000, 2'h0}, 1'b0);
    acc(4'hF, 1'b0, {29'h0000_0000, 2'h0}, 1'b0);
    wr_reg(ADDR_EXT_ID_MASK_4, 8'hF8);
    acc(4'h2, 1'b0, {29'h0000_0000, 2'h2}, 1'b1);
    acc(4'h2, 1'b0, {29'h0000_0000, 2'h1}, 1'b1);
    acc(4'h2, 1'b1, {29'h0000_0000, 2'h2}, 1'b0);
    acc(4'h2, 1'b0, {29'h0000_0001, 2'h3}, 1'b0);
    // A nonzero tag shows that the compare really uses the tag bits
    @(posedge clk);
    tag <= {29'h0020_0000, 2'h2};
    acc(4'h2, 1'b0, {29'h0020_0000, 2'h0}, 1'b1);
    acc(4'h2, 1'b0, {29'h0000_0000, 2'h2}, 1'b0);
    acc(4'h2, 1'b1, {29'h0020_0000, 2'h2}, 1'b1);
    load(4'h2, 3'h6);
    wr_reg(ADDR_MAILBOX_DATA_PORT, 8'hA6);
    wr_reg(ADDR_MAILBOX_DATA_PORT, 8'hA7);
    #1;
    chk("wrap", {13'h0000, idx}, 16'h0000);
    wr_reg(ADDR_MAILBOX_DATA_PORT, 8'hA0);
    load(4'h3, 3'h6);
    wr_reg(ADDR_MAILBOX_DATA_PORT, 8'h36);
    load(4'h2, 3'h6);
    rd_chk(ADDR_MAILBOX_DATA_PORT, 8'hA6, "mbox6");
    rd_chk(ADDR_MAILBOX_DATA_PORT, 8'hA7, "mbox7");
    rd_chk(ADDR_MAILBOX_DATA_PORT, 8'hA0, "mbox0");
    chk("step", {13'h0000, idx}, 16'h0001);
    @(posedge clk);
    ainc <= 1'b0;
    wr_reg(ADDR_MAILBOX_DATA_PORT, 8'hB1);
    rd_chk(ADDR_MAILBOX_DATA_PORT, 8'hB1, "mbox_hold");
    chk("no_step", {13'h0000, idx}, 16'h0001);
    wr_reg(ADDR_TIMER_PRESCALE, 8'h01);
    rd_chk(ADDR_TIMER_PRESCALE, 8'h01, "prescale_rw");
    wr_reg(ADDR_MESSAGE_TIMER_LOW, 8'hFE);
    wr_reg(ADDR_MESSAGE_TIMER_HIGH, 8'h12);
    ticks(4);
    chk("timer_div", tmr, 16'h1300);
    @(posedge clk);
    scap <= 1'b1;
    @(posedge clk);
    scap <= 1'b0;
    rd_chk(ADDR_STAMP_LOW, 8'h00, "stamp_low");
    rd_chk(ADDR_STAMP_HIGH, 8'h13, "stamp_high");
    ticks(2);
    @(posedge clk);
    tcap <= 1'b1;
    @(posedge clk);
    tcap <= 1'b0;
    rd_chk(ADDR_TTC_TIMER_LOW, 8'h01, "ttc_low");
    rd_chk(ADDR_TTC_TIMER_HIGH, 8'h13, "ttc_high");
    wr_reg(ADDR_STAMP_LOW, 8'h55);
    rd_chk(ADDR_STAMP_LOW, 8'h00, "stamp_ro");
    rd_chk(ADDR_MESSAGE_TIMER_LOW, 8'h01, "timer_low");
    wr_reg(ADDR_TIMER_PRESCALE, 8'h00);
    ticks(2);
    chk("timer_fast", tmr, 16'h1303);
    wr_reg(ADDR_TIMER_PRESCALE, 8'h07);
    // Second reset in mid-run: prescaler and timer must return to their reset values
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("timer_rst", tmr, TIMER_RST);
    rd_chk(ADDR_TIMER_PRESCALE, TIMER_PRESCALE_RST, "prescale_rst");
    final_report();
  end
endmodule
